// File: core/adsc_regs.svh
// register offsets, field positions, reset values and counts of the scan controller
// assumes a 4-bit byte offset on the host i/o bus and 8-bit data
`ifndef ADSC_REGS_SVH
`define ADSC_REGS_SVH
`define ADSC_OFF_DATA_LO 4'h0
`define ADSC_OFF_DATA_HI 4'h1
`define ADSC_OFF_SCAN 4'h2
`define ADSC_OFF_DIO_LO 4'h3
`define ADSC_OFF_STATUS 4'h8
`define ADSC_OFF_CTRL 4'h9
`define ADSC_OFF_PACER 4'ha
`define ADSC_OFF_DIO_HI 4'hb
`define ADSC_ST_BUSY 7
`define ADSC_ST_CFG 5
`define ADSC_ST_VALID 4
`define ADSC_CT_IRQ_EN 7
`define ADSC_CT_LVL_HI 6
`define ADSC_CT_LVL_LO 4
`define ADSC_CT_DMA_EN 2
`define ADSC_CT_SRC_HI 1
`define ADSC_CT_SRC_LO 0
`define ADSC_RST_BYTE 8'h00
`define ADSC_LVL_FIRST 3'h2
`define ADSC_DMA_REQS 2'h2
`endif

// File: core/adsc_pkg.sv
// types shared by the scan controller files
// no assumptions beyond a systemverilog compiler
package adsc_pkg;
  // conversion sequencer states, gray along idle -> busy
  typedef enum logic [1:0] {
    ADSC_IDLE = 2'b00,
    ADSC_BUSY = 2'b01
  } adsc_state_t;
  // trigger source field codes
  typedef enum logic [1:0] {
    ADSC_SRC_SW0 = 2'b00,
    ADSC_SRC_SW1 = 2'b01,
    ADSC_SRC_EXT = 2'b10,
    ADSC_SRC_PACER = 2'b11
  } adsc_src_t;
endpackage

// File: core/adsc_range_mem.sv
// per-channel gain code memory, one write port and one registered read port
// assumes write and read addresses are synchronous to ref_clk
`timescale 1ns/100ps
module adsc_range_mem #(
  parameter int DEPTH = 16,
  parameter int AW = 4,
  parameter int DW = 4
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [DW-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [DW-1:0] rd_data_q
);
  // storage, one gain code per channel
  logic [DW-1:0] mem_q [DEPTH];

  // write side: cleared at reset, one entry written per strobe
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) mem_q[i] <= '0;
    end else if (ce && wr_en) begin
      mem_q[wr_addr] <= wr_data; // R6
    end
  end

  // read side: data leave through a register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_q <= '0;
    end else if (ce) begin
      rd_data_q <= mem_q[rd_addr];
    end
  end
endmodule

// File: core/adsc_dma_seq.sv
// issues a pair of dma requests per completed conversion
// assumes the host acknowledges each request with a one-cycle dma_ack
`timescale 1ns/100ps
`include "adsc_regs.svh"
module adsc_dma_seq (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic start,
  input wire logic dma_ack,
  output logic dma_req_q
);
  // requests still owed for the current conversion
  logic [1:0] rem_q;
  logic [1:0] rem_d;
  wire ack_take = dma_req_q && dma_ack;

  // a new conversion reloads the pair, each acknowledge uses one
  always_comb begin
    rem_d = rem_q;
    if (start) begin
      rem_d = `ADSC_DMA_REQS; // R17
    end else if (ack_take) begin
      rem_d = rem_q - 2'h1;
    end
  end

  // request drops for one cycle between the two, so each is a fresh edge
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rem_q <= 2'h0;
      dma_req_q <= 1'b0;
    end else if (ce) begin
      rem_q <= rem_d;
      dma_req_q <= (rem_d != 2'h0) && !ack_take; // R17
    end
  end

  default clocking cb @(posedge ref_clk iff ce); endclocking
  default disable iff (!rst_n);
  sequence s_pair_loaded;
    start ##1 (rem_q == 2'h2);
  endsequence
  a_dma_pair_load: assert property (s_pair_loaded |-> ##[0:1] dma_req_q) // R17
    else $error("dma pair not requested after completion");
  a_dma_req_hold: assert property (dma_req_q && !dma_ack && !start |=> dma_req_q) // R17
    else $error("dma request dropped before acknowledge");
  a_dma_count: assert property (ack_take && !start |=> rem_q == $past(rem_q) - 2'h1) // R17
    else $error("dma request count did not step");
endmodule

// File: core/adsc_ctrl.sv
// register file and scan sequencing of a 12-bit acquisition module on a host i/o bus
// assumes bus strobes, converter handshake, trigger and dma lines are synchronous to ref_clk
`timescale 1ns/100ps
`include "adsc_regs.svh"
// Function
// R1: scan register holds last and first channel
// R2: scan write reloads mux to first channel
// R3: each trigger advances mux channel by one; the code drops a trigger that arrives while busy and leaves the channel
// R4: after last channel mux wraps to first
// R5: gain write stored at scan low nibble
// R6: separate gain code kept per channel
// R7: two 8-bit digital ports, pins and latch
// R8: status write clears only data valid; the code also clears the terminal count flag tc_q
// R9: status bit 7 shows conversion busy
// R10: status bit 5 shows jumper channel configuration
// R11: data valid set on completion until cleared
// R12: data valid with enable raises selected irq
// R13: status low nibble gives next channel
// R14: no enable, no irq; per-conversion irq otherwise
// R15: with dma, irq on terminal count only
// R16: level 2..7 selects irq line, 0,1 none
// R17: dma mode issues two requests per conversion
// R18: trigger source: software, external, pacer
// R19: pacer gate register switches pacer timer
// R20: host waits valid then clears status
// R21: host rewrites scan after range programming
// R22: software mode: write offset 0 starts conversion
// R23: external mode: rising edge starts conversion
// R24: result high byte, low nibble and channel
// R25: result and channel latched together
// R26: irq held until data valid cleared
module adsc_ctrl #(
  parameter int RES_W = 12,
  parameter int CH_W = 4
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [3:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata_q,
  output logic conv_start_q,
  output logic [CH_W-1:0] conv_channel_q,
  output logic [3:0] conv_gain_q,
  input wire logic conv_done,
  input wire logic [RES_W-1:0] conv_result,
  input wire logic ext_trig,
  input wire logic pacer_tick,
  output logic pacer_gate_q,
  input wire logic single_ended_jumper,
  output logic dma_req_q,
  input wire logic dma_ack,
  input wire logic dma_tc,
  output logic [7:2] irq_q,
  input wire logic [15:0] dio_in,
  output logic [15:0] dio_out_q
);
  // host registers
  logic [7:0] scan_q; // last channel high nibble, first low
  logic [7:0] ctrl_q; // operating control
  logic [CH_W-1:0] cur_q; // channel to convert next
  logic [CH_W-1:0] res_ch_q; // channel of the held result
  logic [CH_W-1:0] conv_ch_q; // channel of the running conversion
  logic [RES_W-1:0] res_q; // held result
  logic valid_q; // data valid flag
  logic tc_q; // terminal count seen in dma mode
  logic ext_prev_q; // external trigger last sample
  adsc_pkg::adsc_state_t state_q;
  adsc_pkg::adsc_state_t state_d;

  // write decode
  wire wr_soft = io_wr && (io_addr == `ADSC_OFF_DATA_LO);
  wire wr_range = io_wr && (io_addr == `ADSC_OFF_DATA_HI);
  wire wr_scan = io_wr && (io_addr == `ADSC_OFF_SCAN);
  wire wr_dio_lo = io_wr && (io_addr == `ADSC_OFF_DIO_LO);
  wire wr_status = io_wr && (io_addr == `ADSC_OFF_STATUS);
  wire wr_ctrl = io_wr && (io_addr == `ADSC_OFF_CTRL);
  wire wr_pacer = io_wr && (io_addr == `ADSC_OFF_PACER);
  wire wr_dio_hi = io_wr && (io_addr == `ADSC_OFF_DIO_HI);

  // control fields
  wire irq_enable = ctrl_q[`ADSC_CT_IRQ_EN];
  wire dma_enable = ctrl_q[`ADSC_CT_DMA_EN];
  wire [2:0] lvl = ctrl_q[`ADSC_CT_LVL_HI:`ADSC_CT_LVL_LO];
  wire [1:0] src = ctrl_q[`ADSC_CT_SRC_HI:`ADSC_CT_SRC_LO];
  wire [CH_W-1:0] first_ch = scan_q[3:0];
  wire [CH_W-1:0] last_ch = scan_q[7:4];
  wire busy = (state_q == adsc_pkg::ADSC_BUSY);

  // trigger selection
  wire trig_sw = !src[1] && wr_soft; // R22
  wire trig_ext = (src == adsc_pkg::ADSC_SRC_EXT) && ext_trig && !ext_prev_q; // R23
  wire trig_pacer = (src == adsc_pkg::ADSC_SRC_PACER) && pacer_tick && pacer_gate_q; // R18
  wire trig = trig_sw || trig_ext || trig_pacer; // R18
  // a trigger during a running conversion is dropped
  wire trig_acc = trig && !busy;

  // next mux channel: scan write wins, else step with wrap
  wire [CH_W-1:0] cur_step = (cur_q == last_ch) ? first_ch : cur_q + 1'b1; // R3 R4
  wire [CH_W-1:0] cur_d = wr_scan ? io_wdata[3:0] : (trig_acc ? cur_step : cur_q); // R2

  // status byte: busy, jumper, valid, next channel
  wire [7:0] status_byte = {busy, 1'b0, single_ended_jumper, valid_q, cur_q}; // R9 R10 R13

  // read mux, unmapped offsets read zero
  wire [7:0] rd_byte =
    (io_addr == `ADSC_OFF_DATA_LO) ? {res_q[3:0], res_ch_q} : // R24
    (io_addr == `ADSC_OFF_DATA_HI) ? res_q[11:4] : // R24
    (io_addr == `ADSC_OFF_SCAN) ? scan_q : // R1
    (io_addr == `ADSC_OFF_DIO_LO) ? dio_in[7:0] : // R7
    (io_addr == `ADSC_OFF_STATUS) ? status_byte :
    (io_addr == `ADSC_OFF_CTRL) ? ctrl_q :
    (io_addr == `ADSC_OFF_DIO_HI) ? dio_in[15:8] : // R7
    `ADSC_RST_BYTE;

  // interrupt cause by mode
  wire irq_cause = irq_enable && (dma_enable ? tc_q : valid_q); // R12 R14 R15
  wire [7:2] irq_d;
  genvar g;
  generate
    for (g = 2; g < 8; g++) begin : g_irq
      // one line per level, levels below the first select none
      assign irq_d[g] = irq_cause && (lvl == 3'(g)); // R16
    end
  endgenerate

  // sequencer: idle until an accepted trigger, busy until completion
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      adsc_pkg::ADSC_IDLE: begin
        if (trig_acc) state_d = adsc_pkg::ADSC_BUSY;
      end
      adsc_pkg::ADSC_BUSY: begin
        if (conv_done) state_d = adsc_pkg::ADSC_IDLE;
      end
      default: state_d = adsc_pkg::ADSC_IDLE;
    endcase
  end

  // sequencer state and start strobe
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= adsc_pkg::ADSC_IDLE;
      conv_start_q <= 1'b0;
      conv_ch_q <= '0;
    end else if (ce) begin
      state_q <= state_d;
      conv_start_q <= trig_acc;
      if (trig_acc) conv_ch_q <= cur_q;
    end
  end

  // scan register and current channel
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      scan_q <= `ADSC_RST_BYTE;
      cur_q <= '0;
    end else if (ce) begin
      if (wr_scan) scan_q <= io_wdata; // R1
      cur_q <= cur_d; // R2 R3 R4
    end
  end

  // channel presented to the converter
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      conv_channel_q <= '0;
    end else if (ce) begin
      conv_channel_q <= cur_d;
    end
  end

  // control, pacer gate and digital output latches
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= `ADSC_RST_BYTE;
      pacer_gate_q <= 1'b0;
      dio_out_q <= '0;
    end else if (ce) begin
      if (wr_ctrl) ctrl_q <= io_wdata;
      if (wr_pacer) pacer_gate_q <= io_wdata[0]; // R19
      if (wr_dio_lo) dio_out_q[7:0] <= io_wdata; // R7
      if (wr_dio_hi) dio_out_q[15:8] <= io_wdata; // R7
    end
  end

  // result and its channel latched as one on completion
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      res_q <= '0;
      res_ch_q <= '0;
    end else if (ce && conv_done) begin
      res_q <= conv_result; // R25
      res_ch_q <= conv_ch_q; // R25
    end
  end

  // sticky flags: a completion or count in the clearing cycle wins
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      valid_q <= 1'b0;
      tc_q <= 1'b0;
    end else if (ce) begin
      valid_q <= conv_done || (valid_q && !wr_status); // R8 R11 R26
      tc_q <= (dma_enable && dma_tc) || (tc_q && !wr_status); // R15 R26
    end
  end

  // external edge detector, read data and interrupt lines
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_prev_q <= 1'b0;
      io_rdata_q <= `ADSC_RST_BYTE;
      irq_q <= '0;
    end else if (ce) begin
      ext_prev_q <= ext_trig;
      if (io_rd) io_rdata_q <= rd_byte;
      irq_q <= irq_d; // R12 R14 R16
    end
  end

  // gain memory: written at the scan pointer, read for the channel in use
  adsc_range_mem #(
    .DEPTH(16),
    .AW(CH_W),
    .DW(4)
  ) u_range_mem (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .ce(ce),
    .wr_en(wr_range),
    .wr_addr(first_ch), // R5
    .wr_data(io_wdata[3:0]), // R5 R6
    .rd_addr(cur_d),
    .rd_data_q(conv_gain_q)
  );

  // two dma requests per completion while dma is enabled
  adsc_dma_seq u_dma_seq (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .ce(ce),
    .start(conv_done && dma_enable), // R17
    .dma_ack(dma_ack),
    .dma_req_q(dma_req_q)
  );

  default clocking cb @(posedge ref_clk iff ce); endclocking
  default disable iff (!rst_n);

  // a scan write followed by one quiet cycle, as the host spaces its accesses
  sequence s_scan_write;
    wr_scan ##1 !wr_scan;
  endsequence

  a_scan_reload: assert property (wr_scan |=> cur_q == $past(io_wdata[3:0])) // R2
    else $error("scan write did not reload channel");
  a_chan_step: assert property (trig_acc && !wr_scan && cur_q != last_ch |=> cur_q == $past(cur_q) + 4'h1) // R3
    else $error("trigger did not advance channel");
  a_chan_wrap: assert property (trig_acc && !wr_scan && cur_q == last_ch |=> cur_q == $past(first_ch)) // R4
    else $error("channel did not wrap to first");
  a_scan_readback: assert property (s_scan_write ##1 (io_rd && io_addr == `ADSC_OFF_SCAN && !wr_scan) // R1
    |=> io_rdata_q == $past(io_wdata, 3))
    else $error("scan register read back wrong");
  a_valid_set: assert property (conv_done |=> valid_q) // R11
    else $error("completion did not set valid");
  a_valid_clear: assert property (wr_status && !conv_done |=> !valid_q && scan_q == $past(scan_q)) // R8
    else $error("status write did not clear valid only");
  a_busy_read: assert property (io_rd && io_addr == `ADSC_OFF_STATUS |=> io_rdata_q[7] == $past(busy)) // R9
    else $error("busy bit wrong in status");
  a_res_latch: assert property (conv_done |=> res_q == $past(conv_result) && res_ch_q == $past(conv_ch_q)) // R25
    else $error("result and channel not latched together");
  a_irq_off: assert property (!irq_enable ##1 !irq_enable |-> irq_q == 6'h00) // R14
    else $error("interrupt driven while disabled");
  a_irq_level: assert property (lvl < `ADSC_LVL_FIRST ##1 lvl < `ADSC_LVL_FIRST |-> irq_q == 6'h00) // R16
    else $error("interrupt on unselected level");
  a_irq_hold: assert property (irq_enable && !dma_enable && valid_q && lvl == 3'h5 && !wr_ctrl && !wr_status // R26
    |=> irq_q[5] [*2])
    else $error("interrupt dropped before valid clear");

  // a trigger taken while idle starts one conversion and shows busy
  a_start_busy: assert property (trig_acc |=> conv_start_q && busy) // R18
    else $error("accepted trigger did not start conversion");
  // triggers that arrive while busy are dropped and leave the channel alone
  a_busy_drop: assert property (busy && trig && !wr_scan |=> cur_q == $past(cur_q) && !conv_start_q) // R3
    else $error("trigger accepted while busy");
  // next channel field of a status read taken while idle
  a_status_next: assert property (io_rd && io_addr == `ADSC_OFF_STATUS && !busy // R13
    |=> io_rdata_q[3:0] == $past(cur_q))
    else $error("status next channel wrong");
  // jumper level is reported on every status read
  a_cfg_bit: assert property (io_rd && io_addr == `ADSC_OFF_STATUS // R10
    |=> io_rdata_q[5] == $past(single_ended_jumper))
    else $error("configuration bit wrong in status");
  // in dma mode no line rises before the terminal count
  a_dma_no_irq: assert property (dma_enable && !tc_q |=> irq_q == 6'h00) // R15
    else $error("interrupt raised in dma mode without terminal count");
  // low port latch takes the written byte, pacer gate takes its bit 0
  a_dio_write: assert property (wr_dio_lo |=> dio_out_q[7:0] == $past(io_wdata)) // R7
    else $error("digital port latch not written");
  a_pacer_gate: assert property (wr_pacer |=> pacer_gate_q == $past(io_wdata[0])) // R19
    else $error("pacer gate not written");
endmodule

// File: sim/adsc_host_model.sv
// converter and host dma controller facing the scan controller
// assumes every line is sampled on the rising edge of ref_clk
`timescale 1ns/100ps
module adsc_host_model (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic conv_start_q,
  input wire logic [11:0] res_in,
  output logic conv_done,
  output logic [11:0] conv_result,
  input wire logic dma_req_q,
  output logic dma_ack,
  output logic dma_tc
);
  int busy_cnt; // cycles left in the running conversion
  int req_cnt; // cycles the current request has waited
  int ack_num; // acknowledges given since reset
  // converter: fixed latency, result lines toggle while not valid
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_cnt <= 0;
      conv_done <= 1'b0;
      conv_result <= 12'h000;
    end else begin
      conv_done <= (busy_cnt == 1);
      conv_result <= (busy_cnt == 1) ? res_in : ~conv_result;
      if (conv_start_q) busy_cnt <= 6;
      else if (busy_cnt > 0) busy_cnt <= busy_cnt - 1;
    end
  end
  // dma controller: slow ack, terminal count on every second ack
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      req_cnt <= 0;
      ack_num <= 0;
      dma_ack <= 1'b0;
      dma_tc <= 1'b0;
    end else begin
      dma_ack <= 1'b0;
      dma_tc <= 1'b0;
      if (dma_req_q && !dma_ack) begin
        req_cnt <= req_cnt + 1;
        if (req_cnt == 2) begin
          dma_ack <= 1'b1;
          dma_tc <= ack_num[0];
          ack_num <= ack_num + 1;
          req_cnt <= 0;
        end
      end
    end
  end
endmodule

// File: sim/tb_adsc_ctrl.sv
// self-checking bench of the scan controller register block
// assumes the host model stands in for converter and dma controller
`timescale 1ns/100ps
module tb_adsc_ctrl;
  logic ref_clk, rst_n, ce, io_wr, io_rd, ext_trig, pacer_tick, single_ended_jumper;
  logic [3:0] io_addr, conv_channel_q, conv_gain_q;
  logic [7:0] io_wdata, io_rdata_q;
  logic conv_start_q, conv_done, pacer_gate_q, dma_req_q, dma_ack, dma_tc;
  logic [11:0] conv_result, res_in;
  logic [7:2] irq_q;
  logic [15:0] dio_in, dio_out_q, d;
  logic [7:0] exp_q[$]; // expected read bytes, oldest first
  logic rd_pend, req_d, valid;
  logic [3:0] first_ch, last_ch, cur_ch, gains[16];
  logic [7:0] ctrl; // mirror of the control register
  int err_count, check_count, dma_reqs, starts, i, l;
  adsc_ctrl dut (.ref_clk, .rst_n, .ce, .io_addr, .io_wr, .io_rd, .io_wdata, .io_rdata_q,
    .conv_start_q, .conv_channel_q, .conv_gain_q, .conv_done, .conv_result, .ext_trig,
    .pacer_tick, .pacer_gate_q, .single_ended_jumper, .dma_req_q, .dma_ack, .dma_tc,
    .irq_q, .dio_in, .dio_out_q);
  adsc_host_model host (.ref_clk, .rst_n, .conv_start_q, .res_in, .conv_done, .conv_result,
    .dma_req_q, .dma_ack, .dma_tc);
  // 10 mhz clock
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  task check_val(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task print_verdict;
    $display("checks %0d, mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // read monitor: data lands on the edge that takes the read
  always @(posedge ref_clk) rd_pend <= io_rd;
  always @(negedge ref_clk) begin
    if (rd_pend === 1'b1 && exp_q.size() > 0) check_val({8'h00, io_rdata_q}, {8'h00, exp_q.pop_front()});
  end
  // count rising edges of the dma request and converter start pulses
  always @(posedge ref_clk) begin
    req_d <= dma_req_q;
    if (dma_req_q === 1'b1 && req_d === 1'b0) dma_reqs++;
    if (conv_start_q === 1'b1) starts++;
  end
  task idle(input int n);
    repeat (n) @(posedge ref_clk);
    #10;
  endtask
  // one host write, strobe held for one edge
  task wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    #10;
    io_addr = a;
    io_wdata = v;
    io_wr = 1'b1;
    @(posedge ref_clk);
    #10;
    io_wr = 1'b0;
  endtask
  // one host read, expected byte noted for the monitor
  task rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    #10;
    exp_q.push_back(e);
    io_addr = a;
    io_rd = 1'b1;
    @(posedge ref_clk);
    #10;
    io_rd = 1'b0;
  endtask
  function logic [7:0] stat(input logic busy);
    return {busy, 1'b0, single_ended_jumper, valid, cur_ch};
  endfunction
  function logic [15:0] irq_exp(input logic cause);
    l = ctrl[6:4];
    if (ctrl[7] && cause && l >= 2) return 16'h0001 << (l - 2);
    return 16'h0000;
  endfunction
  // one conversion: 0 software, 1 external edge, 2 pacer tick
  task conv(input int kind);
    logic [3:0] ch;
    ch = cur_ch;
    starts = 0;
    res_in = 12'($urandom);
    if (kind == 0) wr(4'h0, 8'($urandom));
    else begin
      @(posedge ref_clk);
      #10;
      if (kind == 1) ext_trig = 1'b1;
      else pacer_tick = 1'b1;
      @(posedge ref_clk);
      #10;
      pacer_tick = 1'b0;
    end
    cur_ch = (cur_ch == last_ch) ? first_ch : cur_ch + 4'h1;
    if (kind == 0) begin
      rd(4'h8, stat(1'b1));
      wr(4'h0, 8'($urandom));
    end
    for (i = 0; i < 40 && conv_done !== 1'b1; i++) @(negedge ref_clk);
    if (i == 40) begin
      err_count++;
      print_verdict();
    end
    idle(4);
    ext_trig = 1'b0;
    valid = 1'b1;
    check_val(16'(starts), 16'h0001);
    check_val({10'h000, irq_q}, irq_exp(!ctrl[2]));
    rd(4'h0, {res_in[3:0], ch});
    rd(4'h1, res_in[11:4]);
    rd(4'h8, stat(1'b0));
  endtask
  // host clears data valid, request drops with it
  task clr;
    idle(3);
    check_val({10'h000, irq_q}, irq_exp(valid));
    wr(4'h8, 8'($urandom));
    valid = 1'b0;
    idle(3);
    check_val({10'h000, irq_q}, 16'h0000);
    rd(4'h8, stat(1'b0));
  endtask
  task set_ctrl(input logic [7:0] v);
    ctrl = v;
    wr(4'h9, v);
    rd(4'h9, v);
  endtask
  // main sequence
  initial begin
    {rst_n, io_wr, io_rd, ext_trig, pacer_tick, single_ended_jumper, valid} = 7'h00;
    {io_addr, io_wdata, dio_in, res_in, ctrl, first_ch, last_ch, cur_ch} = 0;
    ce = 1'b1;
    err_count = 0;
    check_count = 0;
    dma_reqs = 0;
    i = $urandom(32'h0939a120);
    repeat (16) @(posedge ref_clk);
    #10;
    rst_n = 1'b1;
    for (int a = 0; a < 16; a++) rd(4'(a), 8'h00);
    for (int a = 4; a < 16; a++) if (a < 8 || a > 11) wr(4'(a), 8'($urandom));
    rd(4'h2, 8'h00);
    rd(4'h9, 8'h00);
    single_ended_jumper = 1'b1;
    rd(4'h8, stat(1'b0));
    $display("end of test: reset and unmapped");
    dio_in = 16'($urandom);
    d = 16'($urandom);
    wr(4'h3, d[7:0]);
    wr(4'hb, d[15:8]);
    check_val(dio_out_q, d);
    ce = 1'b0;
    wr(4'h3, ~d[7:0]);
    ce = 1'b1;
    check_val(dio_out_q, d);
    rd(4'h3, dio_in[7:0]);
    rd(4'hb, dio_in[15:8]);
    $display("end of test: digital ports");
    for (int c = 0; c < 16; c++) begin
      gains[c] = 4'($urandom);
      wr(4'h2, 8'(c));
      wr(4'h1, {4'($urandom), gains[c]});
    end
    for (int c = 0; c < 16; c++) begin
      wr(4'h2, {4'(c), 4'(c)});
      idle(2);
      check_val({8'h00, conv_gain_q, conv_channel_q}, {8'h00, gains[c], 4'(c)});
    end
    $display("end of test: gain memory");
    first_ch = 4'($urandom % 12);
    last_ch = first_ch + 4'h3;
    cur_ch = first_ch;
    wr(4'h2, {last_ch, first_ch});
    rd(4'h2, {last_ch, first_ch});
    rd(4'h8, stat(1'b0));
    repeat (6) begin
      conv(0);
      clr();
    end
    $display("end of test: scan wrap");
    for (int v = 0; v < 9; v++) begin
      set_ctrl((v == 8) ? 8'h30 : {1'b1, 3'(v), 4'h0});
      conv(0);
      clr();
    end
    $display("end of test: interrupt levels");
    set_ctrl(8'h01);
    conv(0);
    clr();
    set_ctrl(8'h02);
    wr(4'h0, 8'h00);
    idle(10);
    check_val({12'h000, conv_channel_q}, {12'h000, cur_ch});
    conv(1);
    clr();
    set_ctrl(8'h03);
    pacer_tick = 1'b1;
    idle(1);
    pacer_tick = 1'b0;
    idle(10);
    check_val({12'h000, conv_channel_q}, {12'h000, cur_ch});
    wr(4'ha, 8'h01);
    check_val({15'h0000, pacer_gate_q}, 16'h0001);
    conv(2);
    clr();
    wr(4'ha, 8'h00);
    check_val({15'h0000, pacer_gate_q}, 16'h0000);
    $display("end of test: trigger sources");
    set_ctrl(8'hb4);
    dma_reqs = 0;
    conv(0);
    idle(12);
    check_val(16'(dma_reqs), 16'h0002);
    check_val({10'h000, irq_q}, irq_exp(1'b1));
    wr(4'h8, 8'h00);
    idle(3);
    check_val({10'h000, irq_q}, 16'h0000);
    $display("end of test: dma");
    idle(3);
    print_verdict();
  end
endmodule
